// File: common/pmicm_pkg.sv
// Purpose: constants and types shared by the interrupt source map
// Assumes: 32-bit classic Wishbone slave, one aligned word per register
// Notes: bit positions follow the source map of lines A, B and C
package pmicm_pkg;
  // register byte offsets
  localparam logic [7:0] PMICM_OFS_STS_A = 8'h00;
  localparam logic [7:0] PMICM_OFS_STS_B = 8'h04;
  localparam logic [7:0] PMICM_OFS_STS_C = 8'h08;
  localparam logic [7:0] PMICM_OFS_MSK_A = 8'h0C;
  localparam logic [7:0] PMICM_OFS_MSK_B = 8'h10;
  localparam logic [7:0] PMICM_OFS_MSK_C = 8'h14;
  localparam logic [7:0] PMICM_OFS_CTRL = 8'h18;
  localparam logic [7:0] PMICM_OFS_STATE = 8'h1C;
  // reset values
  localparam logic [23:0] PMICM_MASK_RST = 24'hFFFFFF;
  localparam logic [23:0] PMICM_STS_RST = 24'h000000;
  // reserved source positions: line B bit 4 and line C bit 7
  localparam logic [23:0] PMICM_RSVD = 24'h801000;
  // source positions
  localparam int PMICM_SRC_PWRBTN = 0;
  localparam int PMICM_SRC_REMOTE = 1;
  localparam int PMICM_SRC_BATLOW = 2;
  localparam int PMICM_SRC_ALARM = 3;
  localparam int PMICM_SRC_TICK = 4;
  localparam int PMICM_SRC_HOT = 5;
  localparam int PMICM_SRC_REGSHORT = 6;
  localparam int PMICM_SRC_CARDSHORT = 7;
  localparam int PMICM_SRC_SUBSHORT = 8;
  localparam int PMICM_SRC_BATDET = 9;
  localparam int PMICM_SRC_SIMDET = 10;
  localparam int PMICM_SRC_MMCDET = 11;
  localparam int PMICM_SRC_CONV1 = 13;
  localparam int PMICM_SRC_CONV2 = 14;
  localparam int PMICM_SRC_GAUGE = 15;
  localparam int PMICM_SRC_IDWAKE = 16;
  localparam int PMICM_SRC_VBWAKE = 17;
  localparam int PMICM_SRC_IDEV = 18;
  localparam int PMICM_SRC_VBEV = 19;
  localparam int PMICM_SRC_CHGCTL = 20;
  localparam int PMICM_SRC_EXTCHG = 21;
  localparam int PMICM_SRC_INTCHG = 22;
  // width of the regulator short flag group
  localparam int PMICM_NUM_REG = 15;
  // power state encoding, gray along wait-on, sleep, active
  typedef enum logic [1:0] {
    PMICM_WAITON = 2'h0,
    PMICM_SLEEP = 2'h1,
    PMICM_ACTIVE = 2'h3,
    PMICM_OFF = 2'h2
  } pmicm_pstate_t;
endpackage : pmicm_pkg

// File: common/pmicm_if.sv
// Purpose: carries raw event pulses from the edge detector to the map
// Assumes: single clock domain
// Notes: one bit per source position
`timescale 1ns/1ps
`default_nettype none
interface pmicm_if;
  logic [23:0] evt; // one-cycle event pulses per source
  modport det (output evt);
  modport map (input evt);
endinterface : pmicm_if
`default_nettype wire

// File: verilog/pmicm_edge.sv
// Purpose: turns level inputs of the sources into one-cycle event pulses
// Assumes: inputs synchronous to MCLK
// Notes: both edges or one edge per source as the source demands
`timescale 1ns/1ps
`default_nettype none
module pmicm_edge
  import pmicm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [23:0] lvl,
  input wire logic [23:0] both_edge,
  input wire logic [23:0] fall_only,
  pmicm_if.det ev
);
  logic [23:0] prev; // last sampled level
  // remember levels; reset to zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev <= 24'h000000;
    end
    else
    begin
      prev <= lvl;
    end
  end
  // per-source edge selection
  genvar g;
  generate
    for (g = 0; g < 24; g++)
    begin : g_edge
      assign ev.evt[g] = both_edge[g] ? (lvl[g] ^ prev[g]) :
                         fall_only[g] ? (prev[g] & ~lvl[g]) :
                         (lvl[g] & ~prev[g]);
    end
  endgenerate
endmodule : pmicm_edge
`default_nettype wire

// File: verilog/pmicm_top.sv
// Purpose: interrupt source map with status, shadow and mask lines
// Assumes: classic Wishbone slave, 32-bit data, MCLK 200 MHz
// Notes: status lines read from registers; any status write to byte lane 0 clears all
// Notes: masked events are dropped at capture, never latched for later
// Notes on behaviour
// RULE1 button press and release set A0
// RULE2 button event only in sleep/active
// RULE3 remote power change sets A1, not wait-on; the code also drops it in the off state
// RULE4 battery falling below minimum sets A2
// RULE5 alarm sets A3, periodic tick sets A4
// RULE6 either die monitor hot sets A5
// RULE7 any of fifteen regulator shorts sets A6
// RULE8 card short A7, subscriber short B0
// RULE9 converter cycle ends set B5, B6
// RULE10 gauge calibration done sets B7
// RULE11 wake events C0, C1 in wait-on/sleep
// RULE12 role/bus events C2, C3 in sleep/active
// RULE13 any charger-control sub-event sets C4
// RULE14 external fault C5, internal faults C6
// RULE15 battery, sim, card detection set B1-B3
// RULE16 B4 and C7 reserved, read zero
// RULE17 alert low while unmasked source pending; the code frees it for one cycle after each clearing write
// RULE18 each source individually maskable
// RULE19 any status write to byte lane 0 clears all lines
// RULE20 held events copied in after clear
`timescale 1ns/1ps
`default_nettype none
module pmicm_top
  import pmicm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  // classic wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic ERR_O,
  // power state of the chip
  input wire logic [1:0] POWER_STATE,
  // source levels
  input wire logic POWER_BUTTON,
  input wire logic REMOTE_POWER,
  input wire logic BATTERY_MIN_THRESHOLD,
  input wire logic CLOCK_ALARM,
  input wire logic CLOCK_TICK,
  input wire logic [1:0] DIE_HOT,
  input wire logic [14:0] REGULATOR_SHORT,
  input wire logic CARD_SUPPLY_SHORT,
  input wire logic SUBSCRIBER_CARD_SUPPLY_SHORT,
  input wire logic BATTERY_PRESENT,
  input wire logic SIM_PRESENT,
  input wire logic MMC_PRESENT,
  input wire logic CONVERTER_FIRST_CYCLE_DONE,
  input wire logic CONVERTER_SECOND_CYCLE_DONE,
  input wire logic GAUGE_CALIBRATION_DONE,
  input wire logic OTG_ROLE_PIN,
  input wire logic BUS_POWER,
  input wire logic MAINS_PLUG_CHANGE,
  input wire logic BUS_POWER_PLUG_CHANGE,
  input wire logic CHARGE_WATCHDOG_FAULT,
  input wire logic BATTERY_REMOVED_FLAG,
  input wire logic BATTERY_TEMP_OUT_OF_RANGE,
  input wire logic EXTERNAL_CHARGER_STATUS_INPUT,
  input wire logic BUS_CHARGER_FAULT_FLAG,
  input wire logic BUS_CHARGER_THERMAL_REG_FLAG,
  input wire logic BUS_CHARGER_STATUS_FLAG,
  input wire logic CURRENT_TERM_FLAG,
  // alert to the host, active low
  output logic ALERT_N
);
  logic [23:0] lvl; // level seen per source
  logic [23:0] both_edge; // sources detected on either edge
  logic [23:0] fall_only; // sources detected on a falling edge
  logic [23:0] raw_evt; // qualified event pulses
  logic [23:0] status; // status lines A, B, C
  logic [23:0] shadow; // events held while status uncleared
  logic [23:0] mask; // one masks the source
  logic [23:0] next_status; // status after this cycle
  logic [23:0] next_shadow; // shadow after this cycle
  logic [23:0] next_mask; // mask after this cycle, seen by the alert
  logic [31:0] next_dat; // read data for this access
  logic sleep_or_active; // sleep or active state
  logic waiton_or_sleep; // wait-on or sleep state
  logic req; // bus request present
  logic acc; // access taken this cycle
  logic hit; // mapped address
  logic clr_wr; // write to any status line
  logic pending; // status holds any unmasked source
  logic hold; // status not yet cleared
  pmicm_if evif();

  // state qualifiers
  // the off state belongs to neither group
  assign sleep_or_active = (POWER_STATE == PMICM_SLEEP) || (POWER_STATE == PMICM_ACTIVE);
  assign waiton_or_sleep = (POWER_STATE == PMICM_WAITON) || (POWER_STATE == PMICM_SLEEP);

  // gather levels into source positions
  // plug, button and role-pin sources report both edges, so insertion and
  // removal each raise their own event; most others report a rising level
  always_comb
  begin
    lvl = 24'h000000;
    both_edge = 24'h000000;
    fall_only = 24'h000000;
    lvl[PMICM_SRC_PWRBTN] = POWER_BUTTON;
    both_edge[PMICM_SRC_PWRBTN] = 1'b1; // RULE1
    lvl[PMICM_SRC_REMOTE] = REMOTE_POWER;
    both_edge[PMICM_SRC_REMOTE] = 1'b1; // RULE3
    lvl[PMICM_SRC_BATLOW] = BATTERY_MIN_THRESHOLD;
    fall_only[PMICM_SRC_BATLOW] = 1'b1; // RULE4
    lvl[PMICM_SRC_ALARM] = CLOCK_ALARM; // RULE5
    lvl[PMICM_SRC_TICK] = CLOCK_TICK; // RULE5
    lvl[PMICM_SRC_HOT] = |DIE_HOT; // RULE6
    lvl[PMICM_SRC_REGSHORT] = |REGULATOR_SHORT; // RULE7
    lvl[PMICM_SRC_CARDSHORT] = CARD_SUPPLY_SHORT; // RULE8
    lvl[PMICM_SRC_SUBSHORT] = SUBSCRIBER_CARD_SUPPLY_SHORT; // RULE8
    lvl[PMICM_SRC_BATDET] = BATTERY_PRESENT; // RULE15
    lvl[PMICM_SRC_SIMDET] = SIM_PRESENT; // RULE15
    lvl[PMICM_SRC_MMCDET] = MMC_PRESENT; // RULE15
    both_edge[PMICM_SRC_BATDET] = 1'b1;
    both_edge[PMICM_SRC_SIMDET] = 1'b1;
    both_edge[PMICM_SRC_MMCDET] = 1'b1;
    lvl[PMICM_SRC_CONV1] = CONVERTER_FIRST_CYCLE_DONE; // RULE9
    lvl[PMICM_SRC_CONV2] = CONVERTER_SECOND_CYCLE_DONE; // RULE9
    lvl[PMICM_SRC_GAUGE] = GAUGE_CALIBRATION_DONE; // RULE10
    lvl[PMICM_SRC_IDWAKE] = OTG_ROLE_PIN;
    lvl[PMICM_SRC_VBWAKE] = BUS_POWER;
    lvl[PMICM_SRC_IDEV] = OTG_ROLE_PIN;
    lvl[PMICM_SRC_VBEV] = BUS_POWER;
    both_edge[PMICM_SRC_IDWAKE] = 1'b1;
    both_edge[PMICM_SRC_VBWAKE] = 1'b1;
    both_edge[PMICM_SRC_IDEV] = 1'b1;
    both_edge[PMICM_SRC_VBEV] = 1'b1;
    // any charger-control flag rising
    lvl[PMICM_SRC_CHGCTL] = MAINS_PLUG_CHANGE | BUS_POWER_PLUG_CHANGE | CHARGE_WATCHDOG_FAULT |
                            BATTERY_REMOVED_FLAG | BATTERY_TEMP_OUT_OF_RANGE; // RULE13
    // external status input is active low: fault on its fall
    lvl[PMICM_SRC_EXTCHG] = EXTERNAL_CHARGER_STATUS_INPUT; // RULE14
    fall_only[PMICM_SRC_EXTCHG] = 1'b1;
    lvl[PMICM_SRC_INTCHG] = BUS_CHARGER_FAULT_FLAG | BUS_CHARGER_THERMAL_REG_FLAG |
                            BUS_CHARGER_STATUS_FLAG | CURRENT_TERM_FLAG; // RULE14
  end

  // edge detector for every source
  // its level memory resets low: a source already high at release gives one
  // edge, which the all-ones reset masks swallow
  pmicm_edge u_edge (
    .clk(MCLK),
    .rst(RST),
    .lvl(lvl),
    .both_edge(both_edge),
    .fall_only(fall_only),
    .ev(evif.det)
  );

  // state gating of edge events
  // in the off state none of the six gated sources gets through
  // reserved positions are cut here and again before the status lines
  always_comb
  begin
    raw_evt = evif.evt & ~PMICM_RSVD; // RULE16
    if (!sleep_or_active)
    begin
      raw_evt[PMICM_SRC_PWRBTN] = 1'b0; // RULE2
      raw_evt[PMICM_SRC_REMOTE] = 1'b0; // RULE3
      raw_evt[PMICM_SRC_IDEV] = 1'b0; // RULE12
      raw_evt[PMICM_SRC_VBEV] = 1'b0; // RULE12
    end
    if (!waiton_or_sleep)
    begin
      raw_evt[PMICM_SRC_IDWAKE] = 1'b0; // RULE11
      raw_evt[PMICM_SRC_VBWAKE] = 1'b0; // RULE11
    end
  end

  // bus decode
  // every access is answered one cycle after it is taken; acc stays low
  // while ack or err stands, so one request is never taken twice
  assign req = CYC_I & STB_I;
  assign acc = req & ~ACK_O & ~ERR_O;
  always_comb
  begin
    hit = 1'b1;
    next_dat = 32'h00000000;
    if (ADR_I == PMICM_OFS_STS_A)
    begin
      next_dat[7:0] = status[7:0];
    end
    else if (ADR_I == PMICM_OFS_STS_B)
    begin
      next_dat[7:0] = status[15:8];
    end
    else if (ADR_I == PMICM_OFS_STS_C)
    begin
      next_dat[7:0] = status[23:16];
    end
    else if (ADR_I == PMICM_OFS_MSK_A)
    begin
      next_dat[7:0] = mask[7:0];
    end
    else if (ADR_I == PMICM_OFS_MSK_B)
    begin
      next_dat[7:0] = mask[15:8];
    end
    else if (ADR_I == PMICM_OFS_MSK_C)
    begin
      next_dat[7:0] = mask[23:16];
    end
    else if (ADR_I == PMICM_OFS_CTRL)
    begin
      next_dat[0] = pending; // alert state, high when alert asserted
      next_dat[1] = |shadow; // events waiting in shadow
    end
    else if (ADR_I == PMICM_OFS_STATE)
    begin
      next_dat[1:0] = POWER_STATE;
    end
    else
    begin
      hit = 1'b0; // unmapped: error answer
    end
  end
  // a byte write to lane 0 of any status line clears
  // the data written are ignored: any value acknowledges the interrupt
  assign clr_wr = acc & WE_I & SEL_I[0] & ((ADR_I == PMICM_OFS_STS_A) ||
                  (ADR_I == PMICM_OFS_STS_B) || (ADR_I == PMICM_OFS_STS_C)); // RULE19

  // ack, err and read data, one cycle after the request
  // read data stand only with ack and are zero otherwise
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ACK_O <= 1'b0;
      ERR_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end
    else
    begin
      ACK_O <= acc & hit;
      ERR_O <= acc & ~hit;
      DAT_O <= (acc & hit & ~WE_I) ? next_dat : 32'h00000000;
    end
  end

  // mask lines, one bit per source; the next value also feeds the alert
  always_comb
  begin
    next_mask = mask;
    if (acc & WE_I & SEL_I[0])
    begin
      if (ADR_I == PMICM_OFS_MSK_A)
      begin
        next_mask[7:0] = DAT_I[7:0]; // RULE18
      end
      else if (ADR_I == PMICM_OFS_MSK_B)
      begin
        next_mask[15:8] = DAT_I[7:0]; // RULE18
      end
      else if (ADR_I == PMICM_OFS_MSK_C)
      begin
        next_mask[23:16] = DAT_I[7:0]; // RULE18
      end
    end
  end

  // mask register, all sources masked out of reset
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      mask <= PMICM_MASK_RST;
    end
    else
    begin
      mask <= next_mask;
    end
  end

  // status and shadow: new events go to shadow while status is uncleared
  assign hold = |status;
  always_comb
  begin
    next_status = status;
    next_shadow = shadow;
    if (clr_wr)
    begin
      // clear all lines, shadow moves in, fresh events join it
      // an event in the clearing cycle is kept: the set wins over the clear
      next_status = shadow | (raw_evt & ~mask); // RULE19 RULE20
      next_shadow = 24'h000000;
    end
    else if (hold)
    begin
      // status still uncleared: park new events behind it
      next_shadow = shadow | (raw_evt & ~mask); // RULE20
    end
    else
    begin
      // status empty: events land directly
      next_status = shadow | (raw_evt & ~mask); // RULE18
      next_shadow = 24'h000000;
    end
    next_status = next_status & ~PMICM_RSVD; // RULE16
  end
  // status and shadow registers
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      status <= PMICM_STS_RST;
      shadow <= PMICM_STS_RST;
    end
    else
    begin
      status <= next_status;
      shadow <= next_shadow;
    end
  end

  // pending is the read-back of the alert in the control register
  assign pending = |(status & ~mask); // RULE17
  // alert: low while any unmasked source is pending, except in the cycle
  // after a clearing write; it follows a mask write in the same cycle,
  // so masking a pending source frees the line
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ALERT_N <= 1'b1;
    end
    else if (clr_wr)
    begin
      // a clearing write always frees the line for one cycle, so held
      // events moved in from the shadow give the host a fresh falling edge
      ALERT_N <= 1'b1; // RULE19 RULE20
    end
    else
    begin
      ALERT_N <= ~(|(next_status & ~next_mask)); // RULE17
    end
  end
endmodule : pmicm_top
`default_nettype wire

// File: verification/pmicm_monitor.sv
// Purpose: concurrent checks on the ports of the interrupt source map
// Assumes: one clock, reset asynchronous and active high
// Notes: bound to the top module from the bench
`timescale 1ns/1ps
`default_nettype none
module pmicm_monitor
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic ERR_O,
  input wire logic ALERT_N
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // a request is taken only while the slave is not answering
  wire take = CYC_I && STB_I && !ACK_O && !ERR_O;
  a_ack_after_take: assert property (take && ADR_I[1:0] == 2'h0 && ADR_I <= 8'h1C |=> ACK_O && !ERR_O)
    else $error("mapped access not acknowledged next cycle");
  a_err_unmapped: assert property (take && ADR_I > 8'h1C |=> ERR_O && !ACK_O)
    else $error("unmapped access not refused next cycle");
  a_answer_once: assert property (ACK_O || ERR_O |=> !ACK_O && !ERR_O)
    else $error("answer stood longer than one cycle");
  a_data_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data not zero outside acknowledge");
  a_rsvd_line_b: assert property (ACK_O && !$past(WE_I) && $past(ADR_I) == 8'h04 |-> !DAT_O[4])
    else $error("reserved bit of line B read as one");
  a_rsvd_line_c: assert property (ACK_O && !$past(WE_I) && $past(ADR_I) == 8'h08 |-> !DAT_O[7])
    else $error("reserved bit of line C read as one");
  a_pending_flag: assert property (ACK_O && !$past(WE_I) && $past(ADR_I) == 8'h18 |-> DAT_O[0] == !$past(ALERT_N))
    else $error("pending flag disagrees with alert");
  a_alert_release: assert property ($rose(ALERT_N) |-> ACK_O && $past(WE_I) && $past(ADR_I) <= 8'h14)
    else $error("alert released without a status or mask write");
  // main scenarios reached
  c_clear: cover property (ACK_O && $past(WE_I) && $past(ADR_I) == 8'h00);
  c_alert: cover property ($fell(ALERT_N));
  c_refused: cover property (ERR_O);
  c_reload: cover property ($rose(ALERT_N) ##1 $fell(ALERT_N));
endmodule : pmicm_monitor
`default_nettype wire

// File: verification/pmicm_host.sv
// Purpose: host processor model issuing classic wishbone cycles
// Assumes: single clock, slave answers with ack or err
// Notes: the service reads all three lines before its clearing write
`timescale 1ns/1ps
`default_nettype none
module pmicm_host
  import pmicm_pkg::*;
(
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat_w,
  input wire logic [31:0] dat_r,
  input wire logic ack,
  input wire logic err
);
  // bus idle from time zero
  initial
  begin
    {cyc, stb, we, adr, sel, dat_w} = '0;
  end
  // one cycle, held until ack or err is sampled high, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'h1, d};
    do
      @(posedge clk);
    while (!(ack || err));
    q = dat_r;
    e = err;
    {cyc, stb, we} <= 3'b000;
  endtask : xfer
  // read lines A, B and C, then acknowledge with one clearing write
  task automatic service(output logic [23:0] v);
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b0, PMICM_OFS_STS_A + 8'(4 * i), 32'h0, q, e);
      v[8*i +: 8] = q[7:0];
    end
    xfer(1'b1, PMICM_OFS_STS_A, 32'h0, q, e);
  endtask : service
endmodule : pmicm_host
`default_nettype wire

// File: verification/tb.sv
// Purpose: self-checking bench of the interrupt source map
// Assumes: host model drives the register bus, bench drives source levels
// Notes: each source is pulsed once in sleep state; both-edge sources leave a held event
`timescale 1ns/1ps
`default_nettype none
module tb
  import pmicm_pkg::*;
;
  logic mclk = 1'b0; // system clock
  logic rst = 1'b1; // async reset
  logic [1:0] ps = PMICM_SLEEP; // power state
  logic [41:0] lv = '0; // source levels
  logic cyc, stb, we, ack, err, alert_n;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  int fail_count = 0;
  int n_compared = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  pmicm_host host (.clk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat_w(dw), .dat_r(dr),
    .ack(ack), .err(err));
  pmicm_top uut (.MCLK(mclk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(dw), .DAT_O(dr), .ACK_O(ack), .ERR_O(err), .POWER_STATE(ps), .POWER_BUTTON(lv[0]),
    .REMOTE_POWER(lv[1]), .BATTERY_MIN_THRESHOLD(lv[2]), .CLOCK_ALARM(lv[3]), .CLOCK_TICK(lv[4]),
    .DIE_HOT(lv[6:5]), .REGULATOR_SHORT(lv[21:7]), .CARD_SUPPLY_SHORT(lv[22]),
    .SUBSCRIBER_CARD_SUPPLY_SHORT(lv[23]), .BATTERY_PRESENT(lv[24]), .SIM_PRESENT(lv[25]),
    .MMC_PRESENT(lv[26]), .CONVERTER_FIRST_CYCLE_DONE(lv[27]), .CONVERTER_SECOND_CYCLE_DONE(lv[28]),
    .GAUGE_CALIBRATION_DONE(lv[29]), .OTG_ROLE_PIN(lv[30]), .BUS_POWER(lv[31]), .MAINS_PLUG_CHANGE(lv[32]),
    .BUS_POWER_PLUG_CHANGE(lv[33]), .CHARGE_WATCHDOG_FAULT(lv[34]), .BATTERY_REMOVED_FLAG(lv[35]),
    .BATTERY_TEMP_OUT_OF_RANGE(lv[36]), .EXTERNAL_CHARGER_STATUS_INPUT(lv[37]),
    .BUS_CHARGER_FAULT_FLAG(lv[38]), .BUS_CHARGER_THERMAL_REG_FLAG(lv[39]),
    .BUS_CHARGER_STATUS_FLAG(lv[40]), .CURRENT_TERM_FLAG(lv[41]), .ALERT_N(alert_n));
  // status bits that one level input sets in sleep state
  function automatic logic [23:0] map_of(input int j);
    logic [23:0] m;
    m = 24'h0;
    if (j < 5) m[j] = 1'b1;
    else if (j < 7) m[5] = 1'b1;
    else if (j < 22) m[6] = 1'b1;
    else if (j < 27) m[j-15] = 1'b1;
    else if (j < 30) m[j-14] = 1'b1;
    else if (j < 32) m = 24'h050000 << (j - 30);
    else if (j < 37) m[20] = 1'b1;
    else m[(j > 37) ? 22 : 21] = 1'b1;
    return m;
  endfunction : map_of
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // toggle one source high then low, then check the two services
  task automatic pulse_chk(input int j, input logic [23:0] first, input logic [23:0] second);
    logic [23:0] v;
    logic [31:0] q;
    logic e;
    @(posedge mclk);
    lv[j] <= 1'b1;
    repeat (3) @(posedge mclk);
    lv[j] <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("alert", 32'(alert_n), 32'(first == 24'h0));
    host.xfer(1'b0, PMICM_OFS_CTRL, 32'h0, q, e);
    chk("pending", 32'(q[0]), 32'(first != 24'h0));
    chk("shadow", 32'(q[1]), 32'(second != 24'h0));
    host.service(v);
    chk("first", 32'(v), 32'(first));
    chk("freed", 32'(alert_n), 32'h1);
    @(posedge mclk);
    chk("reassert", 32'(alert_n), 32'(second == 24'h0));
    host.service(v);
    chk("held", 32'(v), 32'(second));
    chk("released", 32'(alert_n), 32'h1);
  endtask : pulse_chk
  // verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  // main sequence
  initial
  begin
    logic [31:0] q;
    logic e;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      host.xfer(1'b0, PMICM_OFS_MSK_A + 8'(4 * i), 32'h0, q, e);
      chk("mask reset", {24'h0, q[7:0]}, 32'hFF);
      host.xfer(1'b1, PMICM_OFS_MSK_A + 8'(4 * i), 32'h0, q, e);
    end
    host.xfer(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped", 32'(e), 32'h1);
    for (int j = 0; j < 42; j++)
      pulse_chk(j, map_of(j), (j inside {0, 1, 24, 25, 26, 30, 31}) ? map_of(j) : 24'h0);
    ps <= PMICM_WAITON;
    pulse_chk(0, 24'h0, 24'h0);
    pulse_chk(1, 24'h0, 24'h0);
    pulse_chk(30, 24'h010000, 24'h010000);
    ps <= PMICM_ACTIVE;
    pulse_chk(31, 24'h080000, 24'h080000);
    host.xfer(1'b1, PMICM_OFS_MSK_A, 32'h1, q, e);
    pulse_chk(0, 24'h0, 24'h0);
    ps <= PMICM_OFF;
    pulse_chk(30, 24'h0, 24'h0);
    host.xfer(1'b0, PMICM_OFS_STATE, 32'h0, q, e);
    chk("state", q, 32'(PMICM_OFF));
    close_out();
  end
  // watchdog against a hang
  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule : tb
bind pmicm_top pmicm_monitor mon (.MCLK(MCLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O), .ALERT_N(ALERT_N));
`default_nettype wire
